// *** core/sbc_regs.svh ***
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH

// Serial mode control register bit positions and reset value.
`define SBC_MODE_ENABLE 7
`define SBC_MODE_COMPARE 6
`define SBC_MODE_WAKE 5
`define SBC_MODE_BIT4 4
`define SBC_MODE_BIT3 3
`define SBC_MODE_BIT2 2
`define SBC_MODE_RESET 8'h00

// Clock source encodings of the two clock select bits.
`define SBC_CLK_EXTERNAL 2'h0
`define SBC_CLK_TIMER 2'h1
`define SBC_CLK_DIV16 2'h2
`define SBC_CLK_DIV8 2'h3

// Bus control and status register bit positions and reset value.
`define SBC_CTL_ACK_EN 5
`define SBC_CTL_ACK_TRIG 4
`define SBC_CTL_CMD_DET 3
`define SBC_CTL_REL_DET 2
`define SBC_CTL_CMD_TRIG 1
`define SBC_CTL_REL_TRIG 0
`define SBC_CTL_RESET 8'h00

// Timing of the internal serial clock, as half periods.
`define SBC_CLK_PERIOD_NS 20
`define SBC_DIV8_HALF_NS 80
`define SBC_DIV16_HALF_NS 160
`define SBC_DIV64_HALF_NS 640
`define SBC_DIV8_HALF_CYC (`SBC_DIV8_HALF_NS / `SBC_CLK_PERIOD_NS)
`define SBC_DIV16_HALF_CYC (`SBC_DIV16_HALF_NS / `SBC_CLK_PERIOD_NS)
`define SBC_DIV64_HALF_CYC (`SBC_DIV64_HALF_NS / `SBC_CLK_PERIOD_NS)

`define SBC_BITS_PER_BYTE 8

`endif

// *** core/sbc_pkg.sv ***
`include "sbc_regs.svh"

package sbc_pkg;

    typedef enum logic [1:0] {
        mode_stop,
        mode_three_wire,
        mode_bus,
        mode_two_wire
    } sbc_mode_t;

    typedef struct packed {
        logic [3:0] first;
        logic [3:0] second;
    } sbc_sync_t;

    typedef struct packed {
        logic enable;
        logic wake;
        logic [4:0] mode_low;
        logic [7:0] own_addr;
        logic [7:0] shreg;
        logic [3:0] bit_cnt;
        logic busy;
        logic done;
        logic so_latch;
        logic rel_det;
        logic cmd_det;
        logic ack_trig;
        logic ack_en;
        logic ack_arm;
        logic ack_drive;
        logic irq;
        logic [6:0] div_cnt;
        logic int_clk;
        logic sclk_prev;
        logic data_prev;
        logic push;
    } sbc_state_t;

    function automatic sbc_mode_t decode_mode(input logic enable,
                                              input logic bit3,
                                              input logic bit2);
        sbc_mode_t m;
        m = mode_stop;
        if (enable && !bit3) begin
            m = mode_three_wire;
        end else if (enable && !bit2) begin
            m = mode_bus;
        end else if (enable) begin
            m = mode_two_wire;
        end
        return m;
    endfunction

    function automatic logic [6:0] half_cycles(input sbc_mode_t m,
                                               input logic [1:0] sel);
        logic [6:0] h;
        h = 7'(`SBC_DIV16_HALF_CYC);
        if (m == mode_two_wire) begin
            h = 7'(`SBC_DIV64_HALF_CYC);
        end else if (sel == `SBC_CLK_DIV8) begin
            h = 7'(`SBC_DIV8_HALF_CYC);
        end
        return h;
    endfunction

endpackage

// *** core/sbc_sync.sv ***
module sbc_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pin levels in and sampled levels out
    input wire logic [3:0] din,
    output logic [3:0] dout
);
    sbc_pkg::sbc_sync_t st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        st_next.first = din;
        st_next.second = st_reg.first;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_reg <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.second;
endmodule // sbc_sync

// *** core/sbc_buf.sv ***
module sbc_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int IW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] entry;
        logic [IW-1:0] wr_idx;
        logic [IW-1:0] rd_idx;
        logic [IW:0] count;
    } sbc_buf_state_t;

    sbc_buf_state_t st_reg, st_next;
    logic do_push, do_pop;

    function automatic logic [IW-1:0] next_idx(input logic [IW-1:0] i);
        return (int'(i) == DEPTH - 1) ? '0 : IW'(i + 1'b1);
    endfunction

    assign in_ready = int'(st_reg.count) < DEPTH;
    assign out_valid = st_reg.count != '0;
    assign out_data = st_reg.entry[st_reg.rd_idx];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (do_push) begin
            st_next.entry[st_reg.wr_idx] = in_data;
            st_next.wr_idx = next_idx(st_reg.wr_idx);
        end
        if (do_pop) begin
            st_next.rd_idx = next_idx(st_reg.rd_idx);
        end
        if (do_push && !do_pop) begin
            st_next.count = st_reg.count + 1'b1;
        end else if (do_pop && !do_push) begin
            st_next.count = st_reg.count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // sbc_buf

// *** core/sbc_channel.sv ***
`include "sbc_regs.svh"

// Operation
// RL1 - Wake off: interrupt at every transfer end.
// RL2 - Wake on: interrupt only on address match.
// RL3 - Low drive ends only at clock falling edge.
// RL4 - Software enables wake after bus goes high.
// RL5 - Compare flag shows address equals shift register.
// RL6 - Compare flag undefined mid-transfer, byte-write ignored.
// RL7 - Disabled: no shifting, counter cleared, flag held.
// RL8 - Enabled: shifting, counting and flag setting allowed.
// RL9 - Mode decoded from enable and mode bits.
// RL10 - Clock pin drive follows enable and source.
// RL11 - Software masks, disables, then clears request.
// RL12 - Control register bit access only, reset zero.
// RL13 - Wire modes use only the two triggers.
// RL14 - Release trigger sets latch, self-clears.
// RL15 - Command trigger clears latch, self-clears.
// RL16 - Software never pulls data low mid-transfer.
// RL17 - Release flag set and clear conditions.
// RL18 - Command flag set and clear conditions.
// RL19 - Acknowledge trigger drives one acknowledge, self-clears.
// RL20 - Software avoids trigger mid-transfer, auto off.
// RL21 - Auto acknowledge on the ninth clock.
// RL22 - Late auto enable acknowledges on next clock.
// RL23 - Shift register write starts eight-bit transfer.
// RL24 - Release and command edges while clock high.
// RL25 - Acknowledge is one clock period low.
// RL26 - Triggers read zero, read-only flags unwritable.
module sbc_channel (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial mode control register access
    input wire logic mode_wr,
    input wire logic [7:0] mode_wr_data,
    input wire logic mode_bit_wr,
    input wire logic [2:0] mode_bit_sel,
    input wire logic mode_bit_val,
    output logic [7:0] mode_rd_data,
    // Bus control and status register bit access
    input wire logic ctl_bit_wr,
    input wire logic [2:0] ctl_bit_sel,
    input wire logic ctl_bit_val,
    output logic [7:0] ctl_rd_data,
    // Shift register and own slave address
    input wire logic shift_wr,
    input wire logic [7:0] shift_wr_data,
    output logic shift_wr_ready,
    output logic [7:0] shift_rd_data,
    input wire logic addr_wr,
    input wire logic [7:0] addr_wr_data,
    // Transfer end request
    input wire logic irq_clr,
    output logic channel_transfer_irq_flag,
    // Received byte stream
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    // Timer output used as clock source
    input wire logic timer_tick,
    // Pins
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe_n,
    output logic serial_out_pin,
    output logic serial_out_pin_oe_n,
    input wire logic serial_in_pin,
    input wire logic bus_data_line_a_in,
    output logic bus_data_line_a_out,
    output logic bus_data_line_a_oe_n,
    input wire logic bus_data_line_b_in,
    output logic bus_data_line_b_out,
    output logic bus_data_line_b_oe_n
);
    sbc_pkg::sbc_state_t st_reg, st_next;
    sbc_pkg::sbc_mode_t cur_mode;
    logic [3:0] pins_sync;
    logic [1:0] clk_sel;
    logic ext_clk, sclk_now, sclk_rise, sclk_fall, data_now, line_now;
    logic line_b_sel, open_drain, lsb_first, gen_run;
    logic start, end_evt, rel_evt, cmd_evt, addr_match, irq_set;
    logic latch_low, drive_low, buf_in_ready;
    logic [7:0] shifted;

    sbc_sync u_sync (
        .clk(clk),
        .resetn(resetn),
        .din({serial_clock_pin_in, bus_data_line_a_in,
              bus_data_line_b_in, serial_in_pin}),
        .dout(pins_sync)
    );

    // Received bytes wait here; a full buffer holds off the next start.
    sbc_buf #(
        .WIDTH(8),
        .DEPTH(2)
    ) u_buf (
        .clk(clk),
        .resetn(resetn),
        .in_valid(st_reg.push),
        .in_ready(buf_in_ready),
        .in_data(st_reg.shreg),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    assign cur_mode = sbc_pkg::decode_mode(st_reg.enable,
        st_reg.mode_low[`SBC_MODE_BIT3],
        st_reg.mode_low[`SBC_MODE_BIT2]); // RL9
    assign clk_sel = st_reg.mode_low[1:0];
    assign ext_clk = clk_sel == `SBC_CLK_EXTERNAL;
    assign sclk_now = ext_clk ? pins_sync[3] : st_reg.int_clk;
    assign sclk_rise = !st_reg.sclk_prev && sclk_now;
    assign sclk_fall = st_reg.sclk_prev && !sclk_now;
    assign line_b_sel = st_reg.mode_low[`SBC_MODE_BIT4];
    assign open_drain = cur_mode == sbc_pkg::mode_bus ||
                        cur_mode == sbc_pkg::mode_two_wire;
    assign lsb_first = cur_mode == sbc_pkg::mode_three_wire &&
                       st_reg.mode_low[`SBC_MODE_BIT2];
    assign line_now = line_b_sel ? pins_sync[1] : pins_sync[2];
    assign data_now = !open_drain ? pins_sync[0] : line_now;

    // Conditions on the data line are only seen while the clock stays high.
    assign rel_evt = cur_mode == sbc_pkg::mode_bus && st_reg.sclk_prev &&
                     sclk_now && line_now && !st_reg.data_prev; // RL24
    assign cmd_evt = cur_mode == sbc_pkg::mode_bus && st_reg.sclk_prev &&
                     sclk_now && !line_now && st_reg.data_prev; // RL24

    assign shift_wr_ready = st_reg.enable && !st_reg.busy &&
        !st_reg.ack_arm && !st_reg.ack_drive && buf_in_ready;
    assign start = shift_wr && shift_wr_ready; // RL23
    assign shifted = lsb_first ? {data_now, st_reg.shreg[7:1]}
                               : {st_reg.shreg[6:0], data_now};
    assign end_evt = st_reg.busy && sclk_rise &&
        st_reg.bit_cnt == 4'(`SBC_BITS_PER_BYTE - 1); // RL23
    assign addr_match = shifted == st_reg.own_addr;

    // Wake mode lets only an address match after release raise the flag.
    assign irq_set = end_evt && (!st_reg.wake ||
        (cur_mode == sbc_pkg::mode_bus && st_reg.rel_det &&
         addr_match)); // RL1 RL2
    assign gen_run = st_reg.enable && !ext_clk &&
        (st_reg.busy || st_reg.ack_arm || st_reg.ack_drive);

    always_comb begin
        st_next = st_reg;
        st_next.push = 1'b0;
        st_next.sclk_prev = sclk_now;
        st_next.data_prev = line_now;

        // The compare position of a byte write is dropped.
        if (mode_wr) begin
            st_next.enable = mode_wr_data[`SBC_MODE_ENABLE];
            st_next.wake = mode_wr_data[`SBC_MODE_WAKE];
            st_next.mode_low = mode_wr_data[4:0]; // RL6
        end
        if (mode_bit_wr && mode_bit_sel == 3'(`SBC_MODE_ENABLE)) begin
            st_next.enable = mode_bit_val;
        end
        if (mode_bit_wr && mode_bit_sel == 3'(`SBC_MODE_WAKE)) begin
            st_next.wake = mode_bit_val;
        end
        if (addr_wr) begin
            st_next.own_addr = addr_wr_data;
        end

        // Internal clock returns to its high idle level before it stops.
        if (gen_run || !st_reg.int_clk) begin
            if (clk_sel == `SBC_CLK_TIMER) begin
                if (timer_tick) begin
                    st_next.int_clk = !st_reg.int_clk;
                end
            end else if (st_reg.div_cnt ==
                         sbc_pkg::half_cycles(cur_mode, clk_sel) - 7'h01) begin
                st_next.div_cnt = 7'h00;
                st_next.int_clk = !st_reg.int_clk;
            end else begin
                st_next.div_cnt = st_reg.div_cnt + 7'h01;
            end
        end else begin
            st_next.div_cnt = 7'h00;
        end

        if (!st_reg.enable) begin
            st_next.busy = 1'b0; // RL7
            st_next.bit_cnt = 4'h0; // RL7
            st_next.rel_det = 1'b0; // RL17
            st_next.cmd_det = 1'b0; // RL18
        end else begin
            if (st_reg.busy && sclk_fall) begin
                st_next.so_latch = lsb_first ? st_reg.shreg[0]
                                             : st_reg.shreg[7]; // RL8
            end
            if (st_reg.busy && sclk_rise) begin
                st_next.shreg = shifted; // RL8
                st_next.bit_cnt = st_reg.bit_cnt + 4'h1; // RL8
            end
            if (end_evt) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
                st_next.push = 1'b1;
                if (st_reg.ack_en) begin
                    st_next.ack_arm = 1'b1; // RL21
                end
                if (cur_mode == sbc_pkg::mode_bus && st_reg.rel_det &&
                    !addr_match) begin
                    st_next.rel_det = 1'b0; // RL17
                end
            end
            if (start) begin
                st_next.shreg = shift_wr_data; // RL23
                st_next.busy = 1'b1;
                st_next.bit_cnt = 4'h0;
                st_next.done = 1'b0;
                st_next.rel_det = 1'b0; // RL17
                st_next.cmd_det = 1'b0; // RL18
            end
            if (rel_evt) begin
                st_next.rel_det = 1'b1; // RL17
                st_next.cmd_det = 1'b0; // RL18
            end
            if (cmd_evt) begin
                st_next.cmd_det = 1'b1; // RL18
            end
        end

        // Acknowledge starts on a falling edge and ends on the next one.
        if (st_reg.ack_arm && sclk_fall && !st_reg.busy) begin
            st_next.ack_arm = 1'b0;
            st_next.ack_drive = 1'b1; // RL25
        end else if (st_reg.ack_drive && sclk_fall) begin
            st_next.ack_drive = 1'b0; // RL3 RL25
            st_next.ack_trig = 1'b0; // RL19
        end

        // Only single-bit writes reach this register; flags are read-only.
        if (ctl_bit_wr && ctl_bit_val) begin // RL12 RL26
            unique case (ctl_bit_sel)
                3'(`SBC_CTL_REL_TRIG): st_next.so_latch = 1'b1; // RL13 RL14
                3'(`SBC_CTL_CMD_TRIG): st_next.so_latch = 1'b0; // RL13 RL15
                3'(`SBC_CTL_ACK_TRIG): begin
                    st_next.ack_trig = 1'b1; // RL19
                    st_next.ack_arm = 1'b1; // RL19
                end
                3'(`SBC_CTL_ACK_EN): begin
                    st_next.ack_en = 1'b1;
                    if (!st_reg.ack_en && st_reg.done && !st_reg.busy) begin
                        st_next.ack_arm = 1'b1; // RL22
                    end
                end
                default: begin
                end
            endcase
        end
        if (ctl_bit_wr && !ctl_bit_val &&
            ctl_bit_sel == 3'(`SBC_CTL_ACK_EN)) begin
            st_next.ack_en = 1'b0; // RL21
        end

        // A new end event wins over a clear in the same cycle.
        st_next.irq = (st_reg.irq && !irq_clr) ||
                      (st_reg.enable && irq_set); // RL1 RL7 RL8
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_reg <= '0; // RL12
            st_reg.so_latch <= 1'b1;
            st_reg.int_clk <= 1'b1;
            st_reg.sclk_prev <= 1'b1;
            st_reg.data_prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // In bus mode, wake releases the latch drive but never a running acknowledge.
    assign latch_low = !st_reg.so_latch &&
        !(st_reg.wake && cur_mode == sbc_pkg::mode_bus); // RL2 RL3
    assign drive_low = open_drain && (latch_low || st_reg.ack_drive);
    assign bus_data_line_a_out = 1'b0;
    assign bus_data_line_a_oe_n = !(drive_low && !line_b_sel); // RL8
    assign bus_data_line_b_out = 1'b0;
    assign bus_data_line_b_oe_n = !(drive_low && line_b_sel); // RL8
    assign serial_out_pin = st_reg.so_latch;
    assign serial_out_pin_oe_n = cur_mode != sbc_pkg::mode_three_wire;

    assign serial_clock_pin_oe_n = ext_clk; // RL10
    assign serial_clock_pin_out = !st_reg.enable || st_reg.int_clk; // RL10

    // The compare bit is only meaningful outside a transfer.
    assign mode_rd_data = {1'b0, st_reg.own_addr == st_reg.shreg,
                           6'h00}; // RL5 RL6
    assign ctl_rd_data = {2'h0, st_reg.ack_en, st_reg.ack_trig,
                          st_reg.cmd_det, st_reg.rel_det, 2'h0}; // RL26
    assign shift_rd_data = st_reg.shreg;
    assign channel_transfer_irq_flag = st_reg.irq;

    property p_irq_on_end;
        @(posedge clk) disable iff (!resetn)
        end_evt && st_reg.enable && !st_reg.wake |=>
            channel_transfer_irq_flag;
    endproperty
    a_irq_on_end: assert property (p_irq_on_end) // RL1
        else $error("transfer end did not raise the request");

    property p_wake_no_match;
        @(posedge clk) disable iff (!resetn)
        end_evt && st_reg.wake && !addr_match && !st_reg.irq
            |=> !channel_transfer_irq_flag;
    endproperty
    a_wake_no_match: assert property (p_wake_no_match) // RL2
        else $error("request raised without an address match");

    property p_compare;
        @(posedge clk) disable iff (!resetn)
        !st_reg.busy && $stable(shift_rd_data) |->
            mode_rd_data[`SBC_MODE_COMPARE] ==
            (shift_rd_data == st_reg.own_addr);
    endproperty
    a_compare: assert property (p_compare) // RL5
        else $error("compare flag disagrees with the registers");

    property p_disabled_hold;
        @(posedge clk) disable iff (!resetn)
        !st_reg.enable ##1 !st_reg.enable |->
            !st_reg.busy && st_reg.bit_cnt == 4'h0 &&
            !ctl_rd_data[`SBC_CTL_REL_DET] &&
            channel_transfer_irq_flag <= $past(channel_transfer_irq_flag);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) // RL7
        else $error("disabled channel still active");

    property p_three_wire;
        @(posedge clk) disable iff (!resetn)
        st_reg.enable && !st_reg.mode_low[`SBC_MODE_BIT3] |->
            !serial_out_pin_oe_n && bus_data_line_a_oe_n &&
            bus_data_line_b_oe_n;
    endproperty
    a_three_wire: assert property (p_three_wire) // RL9
        else $error("three-wire mode pin use wrong");

    property p_clock_pin;
        @(posedge clk) disable iff (!resetn)
        !st_reg.enable && st_reg.mode_low[1:0] != `SBC_CLK_EXTERNAL |->
            !serial_clock_pin_oe_n && serial_clock_pin_out;
    endproperty
    a_clock_pin: assert property (p_clock_pin) // RL10
        else $error("disabled internal clock pin not high");

    property p_rel_trig;
        @(posedge clk) disable iff (!resetn)
        ctl_bit_wr && ctl_bit_val &&
            ctl_bit_sel == 3'(`SBC_CTL_REL_TRIG) |=>
            serial_out_pin && ctl_rd_data[`SBC_CTL_REL_TRIG] == 1'b0;
    endproperty
    a_rel_trig: assert property (p_rel_trig) // RL14
        else $error("release trigger did not set the latch");

    property p_cmd_trig;
        @(posedge clk) disable iff (!resetn)
        ctl_bit_wr && ctl_bit_val &&
            ctl_bit_sel == 3'(`SBC_CTL_CMD_TRIG) |=>
            !serial_out_pin && ctl_rd_data[`SBC_CTL_CMD_TRIG] == 1'b0;
    endproperty
    a_cmd_trig: assert property (p_cmd_trig) // RL15
        else $error("command trigger did not clear the latch");

    property p_rel_clears_cmd;
        @(posedge clk) disable iff (!resetn)
        rel_evt && st_reg.enable |=>
            ctl_rd_data[`SBC_CTL_REL_DET] && !ctl_rd_data[`SBC_CTL_CMD_DET];
    endproperty
    a_rel_clears_cmd: assert property (p_rel_clears_cmd) // RL17 RL18
        else $error("release detection flags wrong");

    property p_start;
        @(posedge clk) disable iff (!resetn)
        start && !rel_evt && !cmd_evt |=>
            st_reg.busy && !ctl_rd_data[`SBC_CTL_REL_DET] &&
            !ctl_rd_data[`SBC_CTL_CMD_DET] && !shift_wr_ready;
    endproperty
    a_start: assert property (p_start) // RL23
        else $error("transfer start not taken");

    property p_ack_ends_on_fall;
        @(posedge clk) disable iff (!resetn)
        st_reg.ack_drive && !sclk_fall |=> st_reg.ack_drive;
    endproperty
    a_ack_ends_on_fall: assert property (p_ack_ends_on_fall) // RL3 RL25
        else $error("acknowledge released away from a falling edge");
endmodule // sbc_channel

// *** testbench/sbc_partner.sv ***
module sbc_partner (
    // Pins as driven by the channel
    input wire logic sck_out,
    input wire logic sck_oe_n,
    input wire logic sdo,
    // Levels presented back to the channel
    output logic sck_in,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ext_clk = 1'b1;
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    int n = 8;
    // The far clock runs only inside frames and idles high.
    assign sck_in = sck_oe_n ? ext_clk : sck_out;
    initial sdi = 1'b1;
    task automatic load(input logic [7:0] b);
        tx = b;
        n = 0;
    endtask
    task automatic frame();
        repeat (8) begin
            #80 ext_clk = 1'b0;
            #80 ext_clk = 1'b1;
        end
    endtask
    // A bit is presented at each falling edge, most significant first.
    always @(negedge sck_in) begin
        if (n < 8) begin
            sdi <= tx[3'(7 - n)];
        end
    end
    // After the last bit the line is let go and shows the inverse.
    always @(posedge sck_in) begin
        if (n < 8) begin
            rx <= {rx[6:0], sdo};
            n <= n + 1;
        end
        if (n == 7) begin
            sdi <= #100 ~tx[0];
        end
    end
endmodule // sbc_partner

// *** testbench/tb_serial_bus_channel_control.sv ***
module tb_serial_bus_channel_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic mode_wr = 1'b0, mode_bit_wr = 1'b0, mode_bit_val = 1'b0;
    logic ctl_bit_wr = 1'b0, ctl_bit_val = 1'b0, shift_wr = 1'b0;
    logic addr_wr = 1'b0, irq_clr = 1'b0, rx_ready = 1'b0, bus_a = 1'b1;
    logic [2:0] mode_bit_sel = 3'h0, ctl_bit_sel = 3'h0;
    logic [7:0] mode_wr_data = 8'h00, shift_wr_data = 8'h00;
    logic [7:0] addr_wr_data = 8'h00, mode_rd, ctl_rd, rx_data, tx, sd;
    logic ready, irq, rx_valid, sck_in, sck_out, sck_oe_n, so, si;
    logic a_oe_n, b_oe_n;
    logic [7:0] exp_q[$];
    int err_count = 0;
    int cmp_count = 0;
    always #10 clk = ~clk;
    sbc_partner p (.sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdo(so),
        .sck_in(sck_in), .sdi(si));
    sbc_channel i_dut (.clk(clk), .resetn(resetn), .mode_wr(mode_wr),
        .mode_wr_data(mode_wr_data), .mode_bit_wr(mode_bit_wr),
        .mode_bit_sel(mode_bit_sel), .mode_bit_val(mode_bit_val),
        .mode_rd_data(mode_rd), .ctl_bit_wr(ctl_bit_wr),
        .ctl_bit_sel(ctl_bit_sel), .ctl_bit_val(ctl_bit_val),
        .ctl_rd_data(ctl_rd), .shift_wr(shift_wr),
        .shift_wr_data(shift_wr_data), .shift_wr_ready(ready),
        .shift_rd_data(), .addr_wr(addr_wr), .addr_wr_data(addr_wr_data),
        .irq_clr(irq_clr), .channel_transfer_irq_flag(irq),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .timer_tick(1'b0), .serial_clock_pin_in(sck_in),
        .serial_clock_pin_out(sck_out), .serial_clock_pin_oe_n(sck_oe_n),
        .serial_out_pin(so), .serial_out_pin_oe_n(), .serial_in_pin(si),
        .bus_data_line_a_in(a_oe_n & bus_a), .bus_data_line_a_out(),
        .bus_data_line_a_oe_n(a_oe_n), .bus_data_line_b_in(b_oe_n),
        .bus_data_line_b_out(), .bus_data_line_b_oe_n(b_oe_n));
    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        @(negedge clk);
    endtask
    task automatic mode(input logic [7:0] d);
        mode_wr_data = d;
        pulse(mode_wr);
    endtask
    task automatic ctl(input logic [2:0] s, input logic v);
        ctl_bit_sel = s;
        ctl_bit_val = v;
        pulse(ctl_bit_wr);
    endtask
    task automatic xfer(input bit ext, input logic [7:0] b);
        int k;
        sd = 8'($urandom);
        p.load(b);
        shift_wr_data = sd;
        pulse(shift_wr);
        if (ext) p.frame();
        for (k = 0; k < 2000 && irq !== 1'b1; k++) @(negedge clk);
        repeat (3) @(negedge clk);
        chk("sent", sd, p.rx);
        chk("irq", 8'h01, 8'(irq));
    endtask
    task automatic pop();
        chk("rx_valid", 8'h01, 8'(rx_valid));
        chk("rx_data", exp_q.pop_front(), rx_data);
        pulse(rx_ready);
    endtask
    initial begin
        #300us;
        err_count++;
        results();
    end
    initial begin
        void'($urandom(75));
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        chk("mode", 8'h40, mode_rd);
        chk("ctl", 8'h00, ctl_rd);
        mode(8'h80);
        ctl(3'h1, 1'b1);
        chk("so", 8'h00, 8'(so));
        ctl(3'h0, 1'b1);
        chk("so", 8'h01, 8'(so));
        chk("ctl", 8'h00, ctl_rd);
        for (int i = 0; i < 6; i++) begin
            mode(i < 3 ? 8'h80 : 8'h83);
            chk("sck_oe_n", 8'(i < 3), 8'(sck_oe_n));
            chk("ready", 8'h01, 8'(ready));
            tx = 8'($urandom);
            addr_wr_data = i[0] ? tx : ~tx;
            pulse(addr_wr);
            exp_q.push_back(tx);
            xfer(i < 3, tx);
            chk("match", 8'(i[0]), 8'(mode_rd[6]));
            if (i < 5) pulse(irq_clr);
            if (i < 4) pop();
        end
        chk("ready", 8'h00, 8'(ready));
        mode_bit_sel = 3'h7;
        mode_bit_val = 1'b0;
        pulse(mode_bit_wr);
        chk("irq held", 8'h01, 8'(irq));
        pulse(irq_clr);
        pop();
        pop();
        ctl(3'h0, 1'b1);
        mode(8'h88);
        bus_a = 1'b0;
        repeat (6) @(negedge clk);
        chk("cmd_det", 8'h08, ctl_rd & 8'h0c);
        bus_a = 1'b1;
        repeat (6) @(negedge clk);
        chk("rel_det", 8'h04, ctl_rd & 8'h0c);
        pulse(mode_bit_wr);
        chk("rel_det", 8'h00, ctl_rd & 8'h0c);
        chk("ready", 8'h00, 8'(ready));
        mode(8'h8b);
        ctl(3'h4, 1'b1);
        chk("ack_trig", 8'h10, ctl_rd & 8'h10);
        repeat (6) @(negedge clk);
        chk("ack", 8'h00, 8'(a_oe_n));
        repeat (10) @(negedge clk);
        chk("ack end", 8'h01, 8'(a_oe_n));
        chk("ack_trig", 8'h00, ctl_rd & 8'h10);
        mode(8'hab);
        ctl(3'h1, 1'b1);
        chk("so", 8'h00, 8'(so));
        chk("wake hiz", 8'h01, 8'(a_oe_n));
        results();
    end
endmodule // tb_serial_bus_channel_control
